// ==== dv/ctrl_model.sv ====
/*
 Behavioural memory controller driving the command pins of the block.
 Assumes the bench calls its task just after a clock edge.
*/
`timescale 1ns/100ps
module ctrl_model (
   input  wire logic                      clk,
   output dram_refresh_pkg::cmd_pins_type pins
);
   // Idle command, clock enable high, termination off from time zero
   initial begin
      pins = 8'hFC;
   end

   // Caller issues commands with banks idle; timings met except the second refresh of refresh_case
   // Runs stay well under eight intervals, so debt never hits its bound
   task automatic cmd(input logic [3:0] code, input logic cke,
                      input logic a12, input logic rn);
      @(posedge clk);
      pins <= {code, cke, rn, 1'b0, a12};
      @(posedge clk);
      // Back to idle, clock enable kept as given
      pins <= {dram_refresh_pkg::CMD_NOP, cke, rn, 2'b00};
   endtask
endmodule

// ==== dv/dram_refresh_self_refresh_tb.sv ====
/*
 Self-checking bench for the refresh and self-refresh block.
 Assumes the controller model owns the command pins.
*/
`timescale 1ns/100ps
module dram_refresh_self_refresh_tb;
   logic                           clk;
   logic                           rst;
   logic                           mr1_dll_disable;
   dram_refresh_pkg::cmd_pins_type pins;
   dram_refresh_pkg::status_type   status;
   int                             err_total;
   int                             cmp_count;
   logic [12:0]                    row0;

   ctrl_model ctrl_model_inst (.clk(clk), .pins(pins));
   dram_refresh_self_refresh dram_refresh_self_refresh_inst (.clk(clk),
      .rst(rst), .pins(pins), .mr1_dll_disable(mr1_dll_disable),
      .status(status));

   // Clock runs free, so it is stable well before exit
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d, checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Sample after the edge's updates have landed
   task automatic after(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic send(input logic [3:0] code, input logic cke,
                       input logic a12);
      ctrl_model_inst.cmd(code, cke, a12, 1'b1);
   endtask

   // Bounded wait on one status bit, cycles taken come back in n
   task automatic wait_bit(input int idx, input int lim, output int n);
      n = 0;
      do begin
         after(1);
         n++;
      end while (status[idx] !== 1'b1 && n < lim);
      if (n >= lim) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   // Second refresh lands while the first still runs and must be lost
   task automatic refresh_case;
      row0 = status.row;
      send(dram_refresh_pkg::CMD_REFRESH, 1'b1, 1'b0);
      after(2);
      chk({status.refresh_start, status.row},
          {1'b1, row0 + 13'h1});
      send(dram_refresh_pkg::CMD_REFRESH, 1'b1, 1'b0);
      after(3);
      chk(status.refresh_busy, 1'b1);
      after(1);
      chk({status.refresh_busy, status.row}, {1'b0, row0 + 13'h1});
   endtask

   task automatic burst_case;
      for (int i = 0; i < 2; i++) begin
         send(i ? dram_refresh_pkg::CMD_WRITE : dram_refresh_pkg::CMD_READ,
              1'b1, i[0]);
         after(2);
         chk({status.burst_strobe, status.burst_chop},
             {1'b1, ~i[0]});
         after(1);
         chk({status.burst_strobe, status.burst_chop},
             {1'b0, ~i[0]});
      end
   endtask

   task automatic sref_case(input logic dis);
      int n;
      @(posedge clk);
      mr1_dll_disable <= dis;
      row0 = status.row;
      send(dram_refresh_pkg::CMD_REFRESH, 1'b0, 1'b0);
      after(2);
      chk({status.self_refresh, status.int_clk_en, status.dll_enable},
          3'b100);
      chk({status.refresh_start, status.row},
          {1'b1, row0 + 13'h1});
      wait_bit(16, 450, n);
      chk(16'(n), 16'(dram_refresh_pkg::REFI_CYCLES) + 16'h1);
      chk({status.self_refresh, status.row}, {1'b1, row0 + 13'h2});
      send(dram_refresh_pkg::CMD_READ, 1'b0, 1'b0);
      after(2);
      chk(status.burst_strobe, 1'b0);
      send(dis ? 4'hF : dram_refresh_pkg::CMD_NOP, 1'b1, 1'b0);
      after(2);
      chk({status.self_refresh, status.int_clk_en, status.dll_enable,
           status.dll_reset}, {2'b01, ~dis, ~dis});
      if (!dis) begin
         chk({status.dll_locked, status.dll_reset}, 2'b01);
         after(1);
         chk(status.dll_reset, 1'b0);
         // Count starts one cycle after the exit edge
         wait_bit(17, 600, n);
         chk(16'(n) + 16'h1, 16'(dram_refresh_pkg::XSDLL_CYCLES));
      end else begin
         after(8);
      end
   endtask

   // Reset pin is still heard while in self-refresh
   task automatic pin_reset_case;
      send(dram_refresh_pkg::CMD_REFRESH, 1'b0, 1'b0);
      after(4);
      row0 = status.row;
      ctrl_model_inst.cmd(dram_refresh_pkg::CMD_NOP, 1'b0, 1'b0, 1'b0);
      after(2);
      chk({status.self_refresh, status.row}, {1'b0, row0});
      ctrl_model_inst.cmd(dram_refresh_pkg::CMD_NOP, 1'b1, 1'b0, 1'b1);
      after(4);
   endtask

   initial begin
      rst = 1'b1;
      mr1_dll_disable = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      after(4);
      chk({status.self_refresh, status.int_clk_en, status.dll_locked,
           status.row}, {3'b011, 13'h0000});
      refresh_case();
      burst_case();
      sref_case(1'b0);
      refresh_case();
      sref_case(1'b1);
      pin_reset_case();
      tally_and_finish();
   end
endmodule

// ==== rtl/dram_refresh_pkg.sv ====
/*
 Constants and types for the DRAM refresh and self-refresh block.
 Assumes a 50 MHz core clock that samples the command pins.
*/
package dram_refresh_pkg;

   localparam int CLK_PERIOD_NS = 20;
   // Figures not printed alongside these rules; plain defaults
   localparam int T_RFC_NS      = 110;
   localparam int T_REFI_NS     = 7800;
   localparam int T_XS_NS       = 120;
   localparam int T_XSDLL_NCK   = 512;

   // Least times round up, the interval rounds down
   localparam logic [7:0] RFC_CYCLES   =
      8'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] REFI_CYCLES  = 9'(T_REFI_NS / CLK_PERIOD_NS);
   localparam logic [7:0] XS_CYCLES    =
      8'((T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] XSDLL_CYCLES = 10'(T_XSDLL_NCK);

   localparam int         ROW_W     = 13;
   localparam logic [12:0] ROW_RESET = 13'h0000;

   // Command codes on {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_WRITE   = 4'h4;
   localparam logic [3:0] CMD_READ    = 4'h5;
   localparam logic [3:0] CMD_NOP     = 4'h7;

   typedef enum logic [3:0] {
      MODE_IDLE = 4'h1,
      MODE_REF  = 4'h2,
      MODE_SREF = 4'h4,
      MODE_EXIT = 4'h8
   } mode_type;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic reset_n;
      logic odt;
      logic a12;
   } cmd_pins_type;

   localparam cmd_pins_type PINS_RESET = 8'hF4;

   typedef struct packed {
      logic               self_refresh;
      logic               int_clk_en;
      logic               dll_enable;
      logic               dll_reset;
      logic               dll_locked;
      logic               refresh_start;
      logic               refresh_busy;
      logic               burst_strobe;
      logic               burst_chop;
      logic [ROW_W-1:0]   row;
   } status_type;

   typedef struct packed {
      cmd_pins_type       sync1;
      cmd_pins_type       sync2;
      logic               cke_prev;
      mode_type           mode;
      logic [7:0]         rfc_cnt;
      logic [8:0]         refi_cnt;
      logic [7:0]         xs_cnt;
      logic [9:0]         lock_cnt;
      logic [ROW_W-1:0]   row;
      logic               dll_on;
      logic               dll_reset;
      logic               refresh_start;
      logic               burst_strobe;
      logic               burst_chop;
   } state_type;

endpackage

// ==== rtl/dram_refresh_self_refresh.sv ====
/*
 Refresh and self-refresh control inside the DRAM: refresh row counter,
 self-refresh entry, internal refresh timer, exit and loop relock, and
 the on-the-fly burst length choice on read and write.
 Assumes the controller keeps its own command timing and refresh budget.
*/
// Contract
// - Device supplies refresh rows itself; ends with all banks idle.
// - Postponed or early count stays frozen during self-refresh.
// - Loop turned off on entry, re-enabled with reset on exit.
// - Only clock enable and reset heard in self-refresh; clock gated.
// - Device starts a refresh itself within minimum time after entry.
// - Address bit 12 picks chop four or eight beats on read or write.
`timescale 1ns/100ps
module dram_refresh_self_refresh (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire dram_refresh_pkg::cmd_pins_type pins,
   input  wire logic                         mr1_dll_disable,
   output      dram_refresh_pkg::status_type status
);

   dram_refresh_pkg::state_type s;
   dram_refresh_pkg::state_type next_s;

   logic [3:0] cmd;
   logic       cke_now;
   logic       is_ref;
   logic       is_sre;
   logic       is_rw;
   logic       is_srx;
   logic       start_ref;

   function automatic logic [3:0] cmd_of(
      input dram_refresh_pkg::cmd_pins_type p);
      cmd_of = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
   endfunction

   // Only the second synchroniser stage is decoded
   assign cmd     = cmd_of(s.sync2);
   assign cke_now = s.sync2.cke;
   assign is_ref  = s.cke_prev && cke_now &&
                    cmd == dram_refresh_pkg::CMD_REFRESH;
   assign is_sre  = s.cke_prev && !cke_now &&
                    cmd == dram_refresh_pkg::CMD_REFRESH;
   assign is_rw   = s.cke_prev && cke_now &&
                    (cmd == dram_refresh_pkg::CMD_READ ||
                     cmd == dram_refresh_pkg::CMD_WRITE);
   assign is_srx  = !s.cke_prev && cke_now &&
                    (s.sync2.cs_n || cmd == dram_refresh_pkg::CMD_NOP);

   always_comb begin
      next_s               = s;
      start_ref            = 1'b0;
      next_s.sync1         = pins;
      next_s.sync2         = s.sync1;
      next_s.cke_prev      = s.sync2.cke;
      next_s.refresh_start = 1'b0;
      next_s.dll_reset     = 1'b0;
      next_s.burst_strobe  = 1'b0;
      if (s.rfc_cnt != 8'h00) begin
         next_s.rfc_cnt = s.rfc_cnt - 8'h01;
      end
      if (s.lock_cnt != 10'h000) begin
         next_s.lock_cnt = s.lock_cnt - 10'h001;
      end
      case (s.mode)
         dram_refresh_pkg::MODE_IDLE: begin
            if (is_ref) begin
               // Address pins ignored; row comes from the counter
               next_s.mode = dram_refresh_pkg::MODE_REF;
               start_ref   = 1'b1;
            end else if (is_sre) begin
               next_s.mode     = dram_refresh_pkg::MODE_SREF;
               next_s.refi_cnt = dram_refresh_pkg::REFI_CYCLES;
               next_s.dll_on   = 1'b0;
               start_ref       = 1'b1;
            end else if (is_rw) begin
               // Bit 12 is never a column bit
               next_s.burst_strobe = 1'b1;
               next_s.burst_chop   = !s.sync2.a12;
            end
         end
         dram_refresh_pkg::MODE_REF: begin
            // Bank state is idle again once the cycle ends
            if (s.rfc_cnt <= 8'h01) begin
               next_s.mode = dram_refresh_pkg::MODE_IDLE;
            end
         end
         dram_refresh_pkg::MODE_SREF: begin
            // Commands other than clock enable are ignored
            // Timer refreshes move only the row, no budget
            if (s.refi_cnt != 9'h000) begin
               next_s.refi_cnt = s.refi_cnt - 9'h001;
            end else if (s.rfc_cnt == 8'h00) begin
               next_s.refi_cnt = dram_refresh_pkg::REFI_CYCLES;
               start_ref       = 1'b1;
            end
            if (is_srx) begin
               next_s.mode      = dram_refresh_pkg::MODE_EXIT;
               next_s.xs_cnt    = dram_refresh_pkg::XS_CYCLES;
               next_s.lock_cnt  = dram_refresh_pkg::XSDLL_CYCLES;
               next_s.dll_on    = !mr1_dll_disable;
               next_s.dll_reset = !mr1_dll_disable;
               // Stale timer count would misdate the next entry refresh
               next_s.refi_cnt  = 9'h000;
            end
         end
         dram_refresh_pkg::MODE_EXIT: begin
            // A timer refresh may still run; it finishes on rfc_cnt
            if (s.xs_cnt != 8'h00) begin
               next_s.xs_cnt = s.xs_cnt - 8'h01;
            end
            if (s.xs_cnt <= 8'h01) begin
               next_s.mode = dram_refresh_pkg::MODE_IDLE;
            end
         end
         default: begin
            next_s.mode = dram_refresh_pkg::MODE_IDLE;
         end
      endcase
      if (start_ref) begin
         next_s.refresh_start = 1'b1;
         next_s.row           = s.row + 13'h0001;
         next_s.rfc_cnt       = dram_refresh_pkg::RFC_CYCLES;
      end
      // Reset pin is heard in every mode, self-refresh included
      if (!s.sync2.reset_n) begin
         next_s.mode          = dram_refresh_pkg::MODE_IDLE;
         next_s.rfc_cnt       = 8'h00;
         next_s.refi_cnt      = 9'h000;
         next_s.xs_cnt        = 8'h00;
         next_s.lock_cnt      = 10'h000;
         next_s.dll_on        = !mr1_dll_disable;
         next_s.refresh_start = 1'b0;
         next_s.burst_strobe  = 1'b0;
         next_s.row           = s.row;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s.sync1         <= dram_refresh_pkg::PINS_RESET;
         s.sync2         <= dram_refresh_pkg::PINS_RESET;
         s.cke_prev      <= 1'b0;
         s.mode          <= dram_refresh_pkg::MODE_IDLE;
         s.rfc_cnt       <= 8'h00;
         s.refi_cnt      <= 9'h000;
         s.xs_cnt        <= 8'h00;
         s.lock_cnt      <= 10'h000;
         s.row           <= dram_refresh_pkg::ROW_RESET;
         s.dll_on        <= 1'b1;
         s.dll_reset     <= 1'b0;
         s.refresh_start <= 1'b0;
         s.burst_strobe  <= 1'b0;
         s.burst_chop    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      status.self_refresh  = s.mode == dram_refresh_pkg::MODE_SREF;
      // Core clock gated while resting
      status.int_clk_en    = s.mode != dram_refresh_pkg::MODE_SREF;
      status.dll_enable    = s.dll_on;
      status.dll_reset     = s.dll_reset;
      status.dll_locked    = s.dll_on && s.lock_cnt == 10'h000;
      status.refresh_start = s.refresh_start;
      status.refresh_busy  = s.rfc_cnt != 8'h00;
      status.burst_strobe  = s.burst_strobe;
      status.burst_chop    = s.burst_chop;
      status.row           = s.row;
   end

   row_step_a: assert property (
      @(posedge clk) disable iff (rst)
      s.refresh_start |-> s.row == $past(s.row) + 13'h0001)
      else $error("refresh row did not advance by one");

   entry_ref_a: assert property (
      @(posedge clk) disable iff (rst)
      s.mode == dram_refresh_pkg::MODE_IDLE && is_sre && s.sync2.reset_n
      |=> status.self_refresh && s.refresh_start && !s.dll_on)
      else $error("no refresh or loop still on at entry");

   loop_off_a: assert property (
      @(posedge clk) disable iff (rst)
      status.self_refresh |-> !status.dll_enable)
      else $error("delay loop enabled during self-refresh");

   loop_relock_a: assert property (
      @(posedge clk) disable iff (rst)
      $fell(status.self_refresh) && s.mode == dram_refresh_pkg::MODE_EXIT
      && !mr1_dll_disable |-> s.dll_reset ##1 !status.dll_locked)
      else $error("loop not reset on self-refresh exit");

   sref_deaf_a: assert property (
      @(posedge clk) disable iff (rst)
      status.self_refresh |-> !status.int_clk_en ##1 !s.burst_strobe)
      else $error("command acted on during self-refresh");

   frozen_a: assert property (
      @(posedge clk) disable iff (rst)
      status.self_refresh && s.refresh_start
      |-> $past(s.refi_cnt) == 9'h000)
      else $error("self-refresh refresh not from the timer");

   burst_pick_a: assert property (
      @(posedge clk) disable iff (rst)
      s.mode == dram_refresh_pkg::MODE_IDLE && is_rw && !is_ref
      && s.sync2.reset_n
      |=> s.burst_strobe && s.burst_chop == !$past(s.sync2.a12))
      else $error("burst length not taken from bit 12");

endmodule
